/* File: logic/spi_cmd_pkg.sv */
// Shared constants and types of the SPI command interpreter
package spi_cmd_pkg;

	// ==========================================================
	// Serial framing
	localparam int BYTE_BITS = 8;

	// ==========================================================
	// Instruction bytes and pattern masks
	localparam logic [7:0] OP_RESET       = 8'hc0;
	localparam logic [7:0] OP_READ        = 8'h03;
	localparam logic [7:0] OP_WRITE       = 8'h02;
	localparam logic [7:0] OP_BIT_MODIFY  = 8'h05;
	localparam logic [7:0] OP_READ_STATUS = 8'ha0;
	localparam logic [7:0] OP_RX_STATUS   = 8'hb0;
	localparam logic [7:0] OP_READ_RX     = 8'h90;
	localparam logic [7:0] OP_READ_RX_MSK = 8'hf9;
	localparam logic [7:0] OP_LOAD_TX     = 8'h40;
	localparam logic [7:0] OP_LOAD_TX_MSK = 8'hf8;
	localparam logic [7:0] OP_RTS         = 8'h80;
	localparam logic [7:0] OP_RTS_MSK     = 8'hf8;

	// ==========================================================
	// Fast pointer targets
	localparam logic [7:0] RX_BUF0_ID     = 8'h61;
	localparam logic [7:0] RX_BUF_STEP    = 8'h10;
	localparam logic [7:0] RX_DATA_OFFSET = 8'h05;
	localparam logic [7:0] TX_BUF0_ID     = 8'h31;
	localparam logic [7:0] TX_BUF_STEP    = 8'h10;
	localparam logic [7:0] TX_DATA_OFFSET = 8'h05;
	localparam logic [2:0] TX_SEL_LAST    = 3'h5;
	localparam logic [2:0] RTS_NONE       = 3'h0;
	localparam logic [1:0] RX_SEL_BUF0    = 2'h1;
	localparam logic [1:0] RX_SEL_BUF1    = 2'h2;
	localparam logic [1:0] RX_SEL_NONE    = 2'h0;

	// ==========================================================
	// Reset values
	localparam logic [7:0] ADDR_RESET     = 8'h00;
	localparam logic [7:0] BYTE_RESET     = 8'h00;
	localparam logic [7:0] FULL_MASK      = 8'hff;

	// ==========================================================
	// Types
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_INSTR,
		ST_ADDR_READ,
		ST_ADDR_WRITE,
		ST_ADDR_MODIFY,
		ST_READ,
		ST_WRITE,
		ST_MASK,
		ST_MODIFY,
		ST_STATUS,
		ST_RX_STATUS,
		ST_IGNORE
	} state_type;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       write;
	} reg_port_type;

	typedef struct packed {
		logic [7:0] tx_rx;
		logic [7:0] rx_match;
	} status_in_type;

endpackage

/* File: logic/spi_pin_sync.sv */
// Two-stage pin synchroniser with serial clock edge detection
`timescale 1ns/1ps
`default_nettype none
module spi_pin_sync (
	input  wire logic sys_clk,
	input  wire logic sys_rst,
	input  wire logic sck,
	input  wire logic cs_n,
	input  wire logic si,
	output logic      sck_rise,
	output logic      sck_fall,
	output logic      cs_active,
	output logic      si_level
);
	// ==========================================================
	// Synchroniser stages
	logic [2:0] stage1;
	logic [2:0] stage2;
	logic       sck_prev;
	logic [2:0] next_stage1;
	logic [2:0] next_stage2;
	logic       next_sck_prev;

	// Stage1 feeds only stage2; all decoding looks at stage2
	always_comb begin
		next_stage1   = {sck, ~cs_n, si};
		next_stage2   = stage1;
		next_sck_prev = stage2[2];
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			stage1   <= 3'h0;
			stage2   <= 3'h0;
			sck_prev <= 1'b0;
		end else begin
			stage1   <= next_stage1;
			stage2   <= next_stage2;
			sck_prev <= next_sck_prev;
		end
	end

	assign sck_rise  = stage2[2] & ~sck_prev;
	assign sck_fall  = ~stage2[2] & sck_prev;
	assign cs_active = stage2[1];
	assign si_level  = stage2[0];
endmodule
`default_nettype wire

/* File: logic/spi_byte_shifter.sv */
// Byte shifter: samples on serial rising edges, drives on falling edges
`timescale 1ns/1ps
`default_nettype none
module spi_byte_shifter #(
	parameter int WIDTH = 8
) (
	input  wire logic             sys_clk,
	input  wire logic             sys_rst,
	input  wire logic             active,
	input  wire logic             sck_rise,
	input  wire logic             sck_fall,
	input  wire logic             si_level,
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] load_byte,
	output logic                  byte_done,
	output logic [WIDTH-1:0]      rx_byte,
	output logic                  so
);
	localparam int CW = $clog2(WIDTH);
	localparam logic [CW-1:0] LAST = CW'(WIDTH - 1);

	generate
		if (WIDTH < 2) begin : g_bad_width
			$error("spi_byte_shifter needs WIDTH of at least 2");
		end
	endgenerate

	// ==========================================================
	// Shift state
	logic [CW-1:0]    count;
	logic [WIDTH-1:0] shift_in;
	logic [WIDTH-1:0] shift_out;
	logic [CW-1:0]    next_count;
	logic [WIDTH-1:0] next_shift_in;
	logic [WIDTH-1:0] next_shift_out;
	logic [WIDTH-1:0] next_rx_byte;
	logic             next_byte_done;
	logic             next_so;

	always_comb begin
		next_count     = count;
		next_shift_in  = shift_in;
		next_shift_out = shift_out;
		next_rx_byte   = rx_byte;
		next_byte_done = 1'b0;
		next_so        = so;
		// A byte cut short by chip select is simply dropped
		if (!active) begin
			next_count = '0;
		end else if (sck_rise) begin
			next_shift_in = {shift_in[WIDTH-2:0], si_level};
			if (count == LAST) begin
				next_count     = '0;
				next_rx_byte   = {shift_in[WIDTH-2:0], si_level};
				next_byte_done = 1'b1;
			end else begin
				next_count = count + CW'(1);
			end
		end
		// Rotating keeps a byte repeating when nothing reloads it
		if (load) begin
			next_shift_out = load_byte;
		end else if (active && sck_fall) begin
			next_so        = shift_out[WIDTH-1];
			next_shift_out = {shift_out[WIDTH-2:0], shift_out[WIDTH-1]};
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			count     <= '0;
			shift_in  <= '0;
			shift_out <= '0;
			rx_byte   <= '0;
			byte_done <= 1'b0;
			so        <= 1'b0;
		end else begin
			count     <= next_count;
			shift_in  <= next_shift_in;
			shift_out <= next_shift_out;
			rx_byte   <= next_rx_byte;
			byte_done <= next_byte_done;
			so        <= next_so;
		end
	end
endmodule
`default_nettype wire

/* File: logic/spi_command_interpreter.sv */
// SPI instruction decoder driving the controller's register file
// ==========================================================
// What this block does
// - Write: instruction, address, then data bytes stored from that address.
// - Further write bytes go to successive addresses while chip select stays low.
// - Each written byte commits on the rising edge of its last bit.
// - A byte cut short by chip select is dropped; earlier bytes stay written.
// - Load transmit buffer sets pointer to one of six buffer locations, no address.
// - Request-to-send sets transmit request for each selected buffer.
// - Request-to-send with no buffer selected does nothing.
// - Quick status instruction returns one status byte.
// - Further clocks repeat the quick status byte.
// - Receive status instruction returns filter match and message type byte.
// - Further clocks repeat the receive status byte.
// - Bit modify: instruction, address, mask, data in one select period.
// - Masked bits take data values; unmasked bits keep their value.
// - Registers without bit modify take the whole data byte.
// - Reset instruction restores registers to defaults and configuration mode.
// - Read instruction plus address shifts out registers from that address.
// - Read receive buffer sets pointer to one of four locations, then reads.
// - Ending a receive buffer read clears that buffer's receive full flag.
// - Quick status bits are also readable as ordinary registers.
// - First byte after select is the instruction; one command per select.
// - Input sampled on rising serial edge, output driven on falling edge.
// - Reads advance the pointer after each byte until chip select rises.
`timescale 1ns/1ps
`default_nettype none
module spi_command_interpreter (
	input  wire logic                       sys_clk,
	input  wire logic                       sys_rst,
	input  wire logic                       sck,
	input  wire logic                       cs_n,
	input  wire logic                       si,
	output logic                            so,
	output logic                            so_oe,
	output spi_cmd_pkg::reg_port_type       reg_port,
	input  wire logic [7:0]                 reg_rdata,
	input  wire logic                       reg_bit_modifiable,
	input  wire spi_cmd_pkg::status_in_type quick_status,
	output logic [2:0]                      transmit_request_set,
	output logic [1:0]                      receive_full_clear,
	output logic                            soft_reset
);
	import spi_cmd_pkg::*;

	// ==========================================================
	// Pin synchronisation and byte shifting
	logic           sck_rise;
	logic           sck_fall;
	logic           cs_active;
	logic           si_level;
	logic           byte_done;
	logic [7:0]     rx_byte;

	spi_pin_sync u_sync (
		.sys_clk   (sys_clk),
		.sys_rst   (sys_rst),
		.sck       (sck),
		.cs_n      (cs_n),
		.si        (si),
		.sck_rise  (sck_rise),
		.sck_fall  (sck_fall),
		.cs_active (cs_active),
		.si_level  (si_level)
	);

	// ==========================================================
	// Sequencer state
	state_type      state;
	logic [7:0]     mask;
	logic [1:0]     rx_sel;
	logic           rx_read;
	logic           read_pending;
	logic           tx_load;
	logic [7:0]     tx_byte;
	logic           so_drive;

	state_type      next_state;
	reg_port_type   next_reg_port;
	logic [7:0]     next_mask;
	logic [1:0]     next_rx_sel;
	logic           next_rx_read;
	logic           next_read_pending;
	logic           next_tx_load;
	logic [7:0]     next_tx_byte;
	logic           next_so_drive;
	logic [2:0]     next_transmit_request_set;
	logic [1:0]     next_receive_full_clear;
	logic           next_soft_reset;

	spi_byte_shifter #(
		.WIDTH (BYTE_BITS)
	) u_shifter (
		.sys_clk   (sys_clk),
		.sys_rst   (sys_rst),
		.active    (cs_active),
		.sck_rise  (sck_rise),
		.sck_fall  (sck_fall),
		.si_level  (si_level),
		.load      (tx_load),
		.load_byte (tx_byte),
		.byte_done (byte_done),
		.rx_byte   (rx_byte),
		.so        (so)
	);

	// ==========================================================
	// Pointer and output-enable helpers
	function automatic logic [7:0] tx_target(input logic [2:0] sel);
		logic [7:0] base;
		base = TX_BUF0_ID + 8'(TX_BUF_STEP * 8'(sel[2:1]));
		return sel[0] ? 8'(base + TX_DATA_OFFSET) : base;
	endfunction

	function automatic logic [7:0] rx_target(input logic n, input logic m);
		logic [7:0] base;
		base = n ? 8'(RX_BUF0_ID + RX_BUF_STEP) : RX_BUF0_ID;
		return m ? 8'(base + RX_DATA_OFFSET) : base;
	endfunction

	function automatic logic drives_output(input state_type st);
		return (st == ST_READ) || (st == ST_STATUS) || (st == ST_RX_STATUS);
	endfunction

	// ==========================================================
	// Next-state logic
	always_comb begin
		next_state                = state;
		next_reg_port             = reg_port;
		next_reg_port.write       = 1'b0;
		next_mask                 = mask;
		next_rx_sel               = rx_sel;
		next_rx_read              = rx_read;
		next_read_pending         = 1'b0;
		next_tx_load              = 1'b0;
		next_tx_byte              = tx_byte;
		next_transmit_request_set = RTS_NONE;
		next_receive_full_clear   = RX_SEL_NONE;
		next_soft_reset           = 1'b0;

		// Advance after the write pulse so the write sees the old address
		if (reg_port.write) begin
			next_reg_port.addr = reg_port.addr + 8'h01;
		end

		// Register file answers combinationally, so one cycle is enough
		if (read_pending) begin
			next_tx_load = 1'b1;
			next_tx_byte = reg_rdata;
		end

		if (!cs_active) begin
			if (state != ST_IDLE && rx_read) begin
				next_receive_full_clear = rx_sel;
			end
			next_rx_read = 1'b0;
			next_state   = ST_IDLE;
		end else if (state == ST_IDLE) begin
			next_state = ST_INSTR;
		end else if (byte_done) begin
			case (state)
				ST_INSTR: begin
					if (rx_byte == OP_RESET) begin
						next_soft_reset = 1'b1;
						next_state      = ST_IGNORE;
					end else if (rx_byte == OP_READ) begin
						next_state = ST_ADDR_READ;
					end else if (rx_byte == OP_WRITE) begin
						next_state = ST_ADDR_WRITE;
					end else if (rx_byte == OP_BIT_MODIFY) begin
						next_state = ST_ADDR_MODIFY;
					end else if (rx_byte == OP_READ_STATUS) begin
						next_tx_load = 1'b1;
						next_tx_byte = quick_status.tx_rx;
						next_state   = ST_STATUS;
					end else if (rx_byte == OP_RX_STATUS) begin
						next_tx_load = 1'b1;
						next_tx_byte = quick_status.rx_match;
						next_state   = ST_RX_STATUS;
					end else if ((rx_byte & OP_READ_RX_MSK) == OP_READ_RX) begin
						next_reg_port.addr = rx_target(rx_byte[2], rx_byte[1]);
						next_rx_sel        = rx_byte[2] ? RX_SEL_BUF1 : RX_SEL_BUF0;
						next_rx_read       = 1'b1;
						next_read_pending  = 1'b1;
						next_state         = ST_READ;
					end else if ((rx_byte & OP_LOAD_TX_MSK) == OP_LOAD_TX
						&& rx_byte[2:0] <= TX_SEL_LAST) begin
						next_reg_port.addr = tx_target(rx_byte[2:0]);
						next_state         = ST_WRITE;
					end else if ((rx_byte & OP_RTS_MSK) == OP_RTS) begin
						if (rx_byte[2:0] != RTS_NONE) begin
							next_transmit_request_set = rx_byte[2:0];
						end
						next_state = ST_IGNORE;
					end else begin
						next_state = ST_IGNORE;
					end
				end
				ST_ADDR_READ: begin
					next_reg_port.addr = rx_byte;
					next_read_pending  = 1'b1;
					next_state         = ST_READ;
				end
				ST_ADDR_WRITE: begin
					next_reg_port.addr = rx_byte;
					next_state         = ST_WRITE;
				end
				ST_ADDR_MODIFY: begin
					next_reg_port.addr = rx_byte;
					next_state         = ST_MASK;
				end
				ST_READ: begin
					next_reg_port.addr = reg_port.addr + 8'h01;
					next_read_pending  = 1'b1;
				end
				ST_WRITE: begin
					next_reg_port.write = 1'b1;
					next_reg_port.wdata = rx_byte;
				end
				ST_MASK: begin
					next_mask  = rx_byte;
					next_state = ST_MODIFY;
				end
				ST_MODIFY: begin
					next_reg_port.write = 1'b1;
					if (reg_bit_modifiable) begin
						next_reg_port.wdata = (reg_rdata & ~mask) | (rx_byte & mask);
					end else begin
						next_reg_port.wdata = rx_byte;
					end
					// One data byte per bit modify; later bytes are dropped
					next_state = ST_IGNORE;
				end
				ST_STATUS: begin
					// Reload keeps the repeated byte current
					next_tx_load = 1'b1;
					next_tx_byte = quick_status.tx_rx;
				end
				ST_RX_STATUS: begin
					next_tx_load = 1'b1;
					next_tx_byte = quick_status.rx_match;
				end
				ST_IGNORE: begin
					next_state = ST_IGNORE;
				end
				default: begin
					next_state = ST_IGNORE;
				end
			endcase
		end

		next_so_drive = cs_active && drives_output(next_state);
	end

	// ==========================================================
	// State registers
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state                <= ST_IDLE;
			reg_port.addr        <= ADDR_RESET;
			reg_port.wdata       <= BYTE_RESET;
			reg_port.write       <= 1'b0;
			mask                 <= FULL_MASK;
			rx_sel               <= RX_SEL_NONE;
			rx_read              <= 1'b0;
			read_pending         <= 1'b0;
			tx_load              <= 1'b0;
			tx_byte              <= BYTE_RESET;
			so_drive             <= 1'b0;
			transmit_request_set <= RTS_NONE;
			receive_full_clear   <= RX_SEL_NONE;
			soft_reset           <= 1'b0;
		end else begin
			state                <= next_state;
			reg_port             <= next_reg_port;
			mask                 <= next_mask;
			rx_sel               <= next_rx_sel;
			rx_read              <= next_rx_read;
			read_pending         <= next_read_pending;
			tx_load              <= next_tx_load;
			tx_byte              <= next_tx_byte;
			so_drive             <= next_so_drive;
			transmit_request_set <= next_transmit_request_set;
			receive_full_clear   <= next_receive_full_clear;
			soft_reset           <= next_soft_reset;
		end
	end

	// Status bytes come straight from quick_status, not through the register file's read path
	assign so_oe = so_drive;
endmodule
`default_nettype wire

/* File: testbench/spi_host_model.sv */
// Behavioural SPI host driving frames in mode 0,0 or 1,1
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	input  wire logic sys_clk,
	input  wire logic so,
	output logic      sck,
	output logic      cs_n,
	output logic      si
);
	// ==========================================================
	// Frame timing
	localparam int HALF = 6;
	logic       idle;
	logic [7:0] last_rx;

	initial begin
		idle = 1'b0;
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end

	// Deselected data line toggles so a stale bit is never mistaken for data
	always @(negedge sys_clk) begin
		if (cs_n)
			si <= ~si;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	task automatic set_mode(input logic idle_high);
		idle = idle_high;
		sck <= idle_high;
		wait_clk(HALF);
	endtask

	task automatic select();
		cs_n <= 1'b0;
		wait_clk(HALF);
	endtask

	// Bits go out MSB first; input is taken at the rising edge
	task automatic xfer(input logic [7:0] tx, input int nbits);
		for (int i = 0; i < nbits; i++) begin
			sck <= 1'b0;
			si <= tx[7 - i];
			wait_clk(HALF);
			sck <= 1'b1;
			last_rx = {last_rx[6:0], so};
			wait_clk(HALF);
		end
	endtask

	task automatic deselect();
		sck <= idle;
		wait_clk(HALF);
		cs_n <= 1'b1;
		wait_clk(4 * HALF);
	endtask
endmodule
`default_nettype wire

/* File: testbench/spi_command_interpreter_properties.sv */
// Port-level assertions for the SPI command interpreter
`timescale 1ns/1ps
`default_nettype none
module spi_command_interpreter_properties (
	input wire logic                       sys_clk,
	input wire logic                       sys_rst,
	input wire logic                       sck,
	input wire logic                       cs_n,
	input wire logic                       so,
	input wire logic                       so_oe,
	input wire spi_cmd_pkg::reg_port_type  reg_port,
	input wire logic [2:0]                 transmit_request_set,
	input wire logic [1:0]                 receive_full_clear,
	input wire logic                       soft_reset
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	// ==========================================================
	// Properties
	a_write_single: assert property (reg_port.write |=> !reg_port.write)
		else $error("write strobe longer than one cycle");
	a_ptr_advance: assert property (
		reg_port.write |=> reg_port.addr == $past(reg_port.addr) + 8'h01)
		else $error("pointer did not advance after write");
	a_write_in_frame: assert property (reg_port.write |-> !$past(cs_n, 6))
		else $error("write without a complete byte in frame");
	a_rts_pulse: assert property (|transmit_request_set |=> transmit_request_set == 3'h0)
		else $error("request pulse too long");
	a_rts_in_frame: assert property (|transmit_request_set |-> !$past(cs_n, 2))
		else $error("request outside a frame");
	a_soft_pulse: assert property (soft_reset |=> !soft_reset)
		else $error("reset pulse too long");
	a_clear_end: assert property (
		|receive_full_clear |-> cs_n && $past(cs_n) && receive_full_clear != 2'h3)
		else $error("flag clear not at frame end");
	a_oe_idle: assert property (cs_n [*5] |-> !so_oe)
		else $error("output driven while deselected");
	a_so_on_fall: assert property ($changed(so) && !cs_n |-> !sck)
		else $error("output changed while serial clock high");
endmodule

bind spi_command_interpreter spi_command_interpreter_properties checker_inst (
	.sys_clk(sys_clk),
	.sys_rst(sys_rst),
	.sck(sck),
	.cs_n(cs_n),
	.so(so),
	.so_oe(so_oe),
	.reg_port(reg_port),
	.transmit_request_set(transmit_request_set),
	.receive_full_clear(receive_full_clear),
	.soft_reset(soft_reset)
);
`default_nettype wire

/* File: testbench/test_spi_command_interpreter.sv */
// Self-checking bench for the SPI command interpreter
`timescale 1ns/1ps
`default_nettype none
module test_spi_command_interpreter;
	import spi_cmd_pkg::*;
	logic          sys_clk = 1'b0;
	logic          sys_rst = 1'b1;
	logic          sck, cs_n, si, so, so_oe, soft_reset;
	reg_port_type  reg_port;
	status_in_type qs = '0;
	logic [2:0]    trs, trs_seen;
	logic [1:0]    rfc, rfc_seen;
	logic          soft_seen, oe_seen, wr_seen;
	logic [7:0]    regs [256];
	logic [7:0]    exp_mem [256];
	logic [7:0]    a, d, m;
	int            seed = 68;
	int            num_errors = 0;
	int            comparisons = 0;

	always #2.5 sys_clk = ~sys_clk;

	spi_host_model spi_host_model_inst (.sys_clk(sys_clk), .so(so), .sck(sck), .cs_n(cs_n),
		.si(si));

	// Arbitrary map: upper half of the space allows masked update
	spi_command_interpreter spi_command_interpreter_inst (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .sck(sck), .cs_n(cs_n), .si(si), .so(so),
		.so_oe(so_oe), .reg_port(reg_port), .reg_rdata(regs[reg_port.addr]),
		.reg_bit_modifiable(reg_port.addr[7]), .quick_status(qs),
		.transmit_request_set(trs), .receive_full_clear(rfc), .soft_reset(soft_reset));

	// ==========================================================
	// Register file and pulse catchers
	always @(posedge sys_clk) begin
		if (reg_port.write)
			regs[reg_port.addr] <= reg_port.wdata;
		trs_seen <= trs_seen | trs;
		rfc_seen <= rfc_seen | rfc;
		soft_seen <= soft_seen | soft_reset;
		oe_seen <= oe_seen | so_oe;
		wr_seen <= wr_seen | reg_port.write;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		comparisons++;
		if (seen !== want) begin
			num_errors++;
			$display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask

	task automatic start(input logic [7:0] op);
		trs_seen = '0;
		rfc_seen = '0;
		soft_seen = 1'b0;
		oe_seen = 1'b0;
		wr_seen = 1'b0;
		spi_host_model_inst.select();
		spi_host_model_inst.xfer(op, 8);
	endtask

	task automatic send(input logic [7:0] b);
		spi_host_model_inst.xfer(b, 8);
	endtask

	task automatic stop();
		spi_host_model_inst.deselect();
	endtask

	task automatic print_verdict();
		$display("comparisons %0d num_errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Hang guard
	initial begin
		repeat (100000) @(posedge sys_clk);
		num_errors++;
		print_verdict();
	end

	// ==========================================================
	// Scenarios, once per serial mode
	initial begin
		for (int i = 0; i < 256; i++) begin
			regs[i] = 8'($random(seed));
			exp_mem[i] = regs[i];
		end
		repeat (8) @(negedge sys_clk);
		sys_rst = 1'b0;
		repeat (4) @(negedge sys_clk);
		for (int md = 0; md < 2; md++) begin
			spi_host_model_inst.set_mode(md[0]);
			a = 8'($random(seed));
			start(OP_WRITE);
			send(a);
			for (int k = 0; k < 3; k++) begin
				d = 8'($random(seed));
				send(d);
				exp_mem[8'(a + k)] = d;
			end
			// Cut-off byte must leave its target untouched
			spi_host_model_inst.xfer(8'h5a, 5);
			stop();
			start(OP_READ);
			send(a);
			for (int k = 0; k < 4; k++) begin
				send(8'h00);
				check(spi_host_model_inst.last_rx, exp_mem[8'(a + k)]);
			end
			stop();
			check({7'h00, oe_seen}, 8'h01);
			check({7'h00, wr_seen}, 8'h00);
			for (int t = 0; t < 6; t++) begin
				a = TX_BUF0_ID + 8'(t / 2) * TX_BUF_STEP + 8'(t % 2) * TX_DATA_OFFSET;
				d = 8'($random(seed));
				start(OP_LOAD_TX | 8'(t));
				send(d);
				stop();
				exp_mem[a] = d;
				check(regs[a], d);
			end
			// Select 6, past the sixth location, must not write anywhere
			start(OP_LOAD_TX | 8'h06);
			send(8'h3c);
			stop();
			check({7'h00, wr_seen}, 8'h00);
			for (int n = 0; n < 8; n++) begin
				start(OP_RTS | 8'(n));
				stop();
				check({5'h00, trs_seen}, 8'(n));
			end
			for (int k = 0; k < 2; k++) begin
				qs = {8'($random(seed)), 8'($random(seed))};
				start(k ? OP_RX_STATUS : OP_READ_STATUS);
				for (int r = 0; r < 2; r++) begin
					send(8'h00);
					check(spi_host_model_inst.last_rx, k ? qs.rx_match : qs.tx_rx);
				end
				stop();
			end
			for (int k = 0; k < 2; k++) begin
				a = {k[0], 7'($random(seed))};
				m = 8'($random(seed));
				d = 8'($random(seed));
				start(OP_BIT_MODIFY);
				send(a);
				send(m);
				send(d);
				stop();
				exp_mem[a] = k ? ((exp_mem[a] & ~m) | (d & m)) : d;
				check(regs[a], exp_mem[a]);
			end
			for (int n = 0; n < 4; n++) begin
				a = RX_BUF0_ID + 8'(n / 2) * RX_BUF_STEP + 8'(n % 2) * RX_DATA_OFFSET;
				start(OP_READ_RX | 8'(n * 2));
				send(8'h00);
				check(spi_host_model_inst.last_rx, exp_mem[a]);
				stop();
				check({6'h00, rfc_seen}, n < 2 ? 8'h01 : 8'h02);
			end
			start(OP_RESET);
			stop();
			check({7'h00, soft_seen}, 8'h01);
			start(8'hff);
			send(OP_READ);
			send(8'h00);
			stop();
			check({7'h00, oe_seen}, 8'h00);
			check({7'h00, wr_seen}, 8'h00);
		end
		print_verdict();
	end
endmodule
`default_nettype wire
